// [frequency_ramp_sequencer.sv]
// frequency ramp sequencer: two-segment ramp, burst count, triggers, calibration wait
// assumes one clock serving as phase-detector and state-machine clock, an apb master,
// and a vco calibration engine on the same clock answering with a done level

`timescale 1ns/1ps
`default_nettype none

module frequency_ramp_sequencer #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // ramp pins from the external controller
  input wire logic i_sweep_clock_pin,
  input wire logic i_sweep_direction_pin,
  // vco calibration engine
  input wire logic i_cal_done,
  output logic o_cal_request,
  // ramp outputs
  output logic [31:0] o_ramp_offset,
  output logic o_ramp_active,
  output logic o_segment_one
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (ADDR_W < 11) begin : g_addr_check
    $error("ADDR_W must be at least 11 to decode the upper address bits");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [ramp_seq_pkg::NUM_CFG-1:0][15:0] cfg;
    logic run;
    logic clk_s1;
    logic clk_s2;
    logic clk_p;
    logic dir_s1;
    logic dir_s2;
    logic dir_p;
    ramp_seq_pkg::seq_state_t state;
    logic [16:0] cal_cnt;
    logic [15:0] len_cnt;
    logic half_ph;
    logic [31:0] offset;
    logic [31:0] seg_one_base;
    logic seg_one_seen;
    logic [12:0] burst_left;
    logic cal_req;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic active;
    logic seg_one_out;
  } seq_regs_t;

  seq_regs_t s_q;
  seq_regs_t s_d;

  // trigger code decode against the synchronised pin edges
  function automatic logic trig_hit(input logic [3:0] code, input logic ck_r,
                                    input logic ck_f, input logic dr_r, input logic dr_f);
    logic hit;
    hit = 1'b0;
    case (code)
      ramp_seq_pkg::TRIG_CLOCK_RISE: hit = ck_r;
      ramp_seq_pkg::TRIG_DIR_RISE: hit = dr_r;
      ramp_seq_pkg::TRIG_ALWAYS: hit = 1'b1;
      ramp_seq_pkg::TRIG_CLOCK_FALL: hit = ck_f;
      ramp_seq_pkg::TRIG_DIR_FALL: hit = dr_f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // advance decode for a two-bit source field
  function automatic logic src_hit(input logic [1:0] src, input logic base,
                                   input logic ta, input logic tb);
    logic hit;
    hit = 1'b0;
    case (src)
      ramp_seq_pkg::SRC_TRANSITION: hit = base;
      ramp_seq_pkg::SRC_TRIG_A: hit = ta;
      ramp_seq_pkg::SRC_TRIG_B: hit = tb;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [7:0] idx;
    logic [3:0] cfg_sel;
    logic cfg_hit;
    logic [15:0] rd16;
    logic access;
    logic ck_r;
    logic ck_f;
    logic dr_r;
    logic dr_f;
    logic trig_a;
    logic trig_b;
    logic [15:0] r_burst;
    logic [15:0] r_trig;
    logic [15:0] r_seq0;
    logic [15:0] r_mode;
    logic manual;
    logic in_seg;
    logic seg1;
    logic half;
    logic tick;
    logic [15:0] dur;
    logic [16:0] len_next;
    logic timeout;
    logic advance;
    logic next_seg1;
    logic [29:0] step;
    logic [16:0] cal_target;
    logic burst_on;
    logic burst_evt;
    idx = 8'h00;
    cfg_sel = 4'h0;
    cfg_hit = 1'b0;
    rd16 = 16'h0000;
    s_d = s_q;
    s_d.cal_req = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // pin synchronisers and edge detection, first stage read only by the second
    s_d.clk_s1 = i_sweep_clock_pin;
    s_d.clk_s2 = s_q.clk_s1;
    s_d.clk_p = s_q.clk_s2;
    s_d.dir_s1 = i_sweep_direction_pin;
    s_d.dir_s2 = s_q.dir_s1;
    s_d.dir_p = s_q.dir_s2;
    ck_r = s_q.clk_s2 & ~s_q.clk_p;
    ck_f = ~s_q.clk_s2 & s_q.clk_p;
    dr_r = s_q.dir_s2 & ~s_q.dir_p;
    dr_f = ~s_q.dir_s2 & s_q.dir_p;

    // configuration fields
    r_burst = s_q.cfg[0];
    r_trig = s_q.cfg[1];
    r_seq0 = s_q.cfg[5];
    r_mode = s_q.cfg[9];
    manual = r_mode[ramp_seq_pkg::MANUAL_BIT];
    trig_a = trig_hit(r_trig[ramp_seq_pkg::TRIG_A_HI:ramp_seq_pkg::TRIG_A_LO],
                      ck_r, ck_f, dr_r, dr_f);
    trig_b = trig_hit(r_trig[ramp_seq_pkg::TRIG_B_HI:ramp_seq_pkg::TRIG_B_LO],
                      ck_r, ck_f, dr_r, dr_f);
    burst_on = r_burst[ramp_seq_pkg::BURST_ENABLE_BIT];

    // per-segment selection of step, duration, half rate and advance
    seg1 = (s_q.state == ramp_seq_pkg::ST_SEG_ONE);
    in_seg = seg1 | (s_q.state == ramp_seq_pkg::ST_SEG_ZERO);
    if (seg1) begin
      step = {s_q.cfg[6][ramp_seq_pkg::SEG_ONE_STEP_HIGH_HI:0], s_q.cfg[7]};
      dur = s_q.cfg[8];
      half = r_seq0[ramp_seq_pkg::SEG_ONE_HALF_RATE_BIT];
      next_seg1 = r_mode[ramp_seq_pkg::SUCCESSOR_BIT];
    end else begin
      step = {s_q.cfg[2][ramp_seq_pkg::STEP_HIGH_HI:ramp_seq_pkg::STEP_HIGH_LO],
              s_q.cfg[3]};
      dur = s_q.cfg[4];
      half = s_q.cfg[2][ramp_seq_pkg::SEG_ZERO_HALF_RATE_BIT];
      next_seg1 = r_seq0[ramp_seq_pkg::SUCCESSOR_BIT];
    end
    tick = ~half | s_q.half_ph;
    len_next = {1'b0, s_q.len_cnt} + 17'h00001;
    timeout = tick & (len_next >= {1'b0, dur});
    advance = seg1 ? src_hit(r_mode[ramp_seq_pkg::SOURCE_HI:0], timeout, trig_a, trig_b)
                   : src_hit(r_seq0[ramp_seq_pkg::SOURCE_HI:0], timeout, trig_a,
                             trig_b);
    burst_evt = src_hit(r_trig[ramp_seq_pkg::SOURCE_HI:0], in_seg & advance, trig_a,
                        trig_b);
    cal_target = 17'({7'h00, r_mode[ramp_seq_pkg::CAL_WAIT_HI:ramp_seq_pkg::CAL_WAIT_LO]}
                     << s_q.cfg[10][ramp_seq_pkg::SCALE_HI:0]);

    // ramp sequencer
    case (s_q.state)
      ramp_seq_pkg::ST_IDLE: begin
        if (s_q.run) begin
          s_d.offset = 32'h00000000;
          s_d.seg_one_seen = 1'b0;
          s_d.burst_left = r_burst[ramp_seq_pkg::BURST_TOTAL_HI:ramp_seq_pkg::BURST_TOTAL_LO];
          s_d.len_cnt = 16'h0000;
          s_d.half_ph = 1'b0;
          s_d.cal_cnt = 17'h00000;
          if (burst_on && r_burst[ramp_seq_pkg::BURST_TOTAL_HI:ramp_seq_pkg::BURST_TOTAL_LO]
              == 13'h0000) begin
            s_d.state = ramp_seq_pkg::ST_DONE;
          end else if (manual) begin
            s_d.state = ramp_seq_pkg::ST_SEG_ZERO;
          end else begin
            s_d.cal_req = 1'b1;
            s_d.state = ramp_seq_pkg::ST_CAL;
          end
        end
      end
      ramp_seq_pkg::ST_CAL: begin
        if (s_q.cal_cnt < cal_target) begin
          s_d.cal_cnt = s_q.cal_cnt + 17'h00001;
        end else if (i_cal_done) begin
          s_d.state = ramp_seq_pkg::ST_SEG_ZERO;
        end
      end
      ramp_seq_pkg::ST_SEG_ZERO, ramp_seq_pkg::ST_SEG_ONE: begin
        s_d.half_ph = half & ~s_q.half_ph;
        if (tick) begin
          s_d.offset = s_q.offset + 32'(signed'(step));
          s_d.len_cnt = len_next[15:0];
        end
        if (advance) begin
          s_d.len_cnt = 16'h0000;
          s_d.half_ph = 1'b0;
          s_d.cal_req = s_q.cfg[10][ramp_seq_pkg::POST_CAL_BIT];
          if (next_seg1) begin
            s_d.state = ramp_seq_pkg::ST_SEG_ONE;
            if (!s_q.seg_one_seen) begin
              s_d.seg_one_base = s_d.offset;
              s_d.seg_one_seen = 1'b1;
            end else if (r_seq0[ramp_seq_pkg::SEG_ONE_RESTART_BIT] && !manual) begin
              s_d.offset = s_q.seg_one_base;
            end
          end else begin
            s_d.state = ramp_seq_pkg::ST_SEG_ZERO;
            if (r_trig[ramp_seq_pkg::SEG_ZERO_RESTART_BIT] && !manual) begin
              s_d.offset = 32'h00000000;
            end
          end
        end
        if (burst_on && burst_evt) begin
          s_d.burst_left = s_q.burst_left - 13'h0001;
          if (s_q.burst_left == 13'h0001) begin
            s_d.state = ramp_seq_pkg::ST_DONE;
            s_d.cal_req = s_q.cfg[10][ramp_seq_pkg::POST_CAL_BIT];
          end
        end
      end
      ramp_seq_pkg::ST_DONE: begin
        s_d.state = ramp_seq_pkg::ST_DONE;
      end
      default: begin
        s_d.state = ramp_seq_pkg::ST_IDLE;
      end
    endcase
    if (!s_q.run) begin
      s_d.state = ramp_seq_pkg::ST_IDLE;
    end
    // ramp flags registered from the next state so the outputs come from flops
    s_d.active = (s_d.state == ramp_seq_pkg::ST_SEG_ZERO)
                 | (s_d.state == ramp_seq_pkg::ST_SEG_ONE);
    s_d.seg_one_out = (s_d.state == ramp_seq_pkg::ST_SEG_ONE);

    // apb decode and register access
    access = i_psel & i_penable;
    idx = i_paddr[9:2];
    if (idx >= ramp_seq_pkg::IDX_BURST_CONTROL && idx <= ramp_seq_pkg::IDX_WAIT_SCALE) begin
      cfg_hit = 1'b1;
      cfg_sel = 4'(idx - ramp_seq_pkg::IDX_BURST_CONTROL);
      rd16 = s_q.cfg[cfg_sel];
    end else if (idx == ramp_seq_pkg::IDX_RUN_CONTROL) begin
      rd16 = {s_q.run, 15'h0000};
    end else if (idx == ramp_seq_pkg::IDX_STATUS) begin
      rd16 = {in_seg, s_q.state == ramp_seq_pkg::ST_DONE, seg1, s_q.burst_left};
    end else if (idx == ramp_seq_pkg::IDX_OFFSET_HIGH) begin
      rd16 = s_q.offset[31:16];
    end else if (idx == ramp_seq_pkg::IDX_OFFSET_LOW) begin
      rd16 = s_q.offset[15:0];
    end
    if (access && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = {16'h0000, rd16};
      s_d.pslverr = ~(cfg_hit | idx == ramp_seq_pkg::IDX_RUN_CONTROL
                      | idx == ramp_seq_pkg::IDX_STATUS | idx == ramp_seq_pkg::IDX_OFFSET_HIGH
                      | idx == ramp_seq_pkg::IDX_OFFSET_LOW) | (i_paddr[1:0] != 2'h0)
                    | (i_paddr[ADDR_W-1:10] != '0)
                    | (i_pwrite & ~(cfg_hit | idx == ramp_seq_pkg::IDX_RUN_CONTROL));
    end
    if (access && s_q.pready && i_pwrite && !s_q.pslverr) begin
      if (cfg_hit) begin
        s_d.cfg[cfg_sel] = i_pwdata[15:0] & ramp_seq_pkg::CFG_MASK[cfg_sel];
      end else begin
        s_d.run = i_pwdata[ramp_seq_pkg::RUN_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.cfg <= ramp_seq_pkg::CFG_RESET;
      s_q.state <= ramp_seq_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs taken straight from the state register
  assign o_pready = s_q.pready;
  assign o_prdata = s_q.prdata;
  assign o_pslverr = s_q.pslverr;
  assign o_cal_request = s_q.cal_req;
  assign o_ramp_offset = s_q.offset;
  assign o_ramp_active = s_q.active;
  assign o_segment_one = s_q.seg_one_out;

endmodule

`default_nettype wire

// [frequency_ramp_sequencer_checker.sv]
// concurrent checks on the ports of the frequency ramp sequencer
// assumes an apb master that holds each request until pready is sampled high
`timescale 1ns/1ps
`default_nettype none

module ramp_seq_checker #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // ramp outputs
  input wire logic [31:0] o_ramp_offset,
  input wire logic o_ramp_active,
  input wire logic o_segment_one
);
  // ****************************************************************
  // properties, all on the one clock
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // first access cycle, then exactly one wait before the answer
  sequence s_access_first;
    i_psel && $rose(i_penable);
  endsequence
  sequence s_one_wait;
    !o_pready ##1 o_pready;
  endsequence
  property p_ready_timing;
    s_access_first |-> s_one_wait;
  endproperty
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  property p_ready_in_access;
    o_pready |-> i_psel && i_penable && $past(i_penable);
  endproperty
  property p_err_with_ready;
    o_pslverr |-> o_pready;
  endproperty
  property p_unaligned;
    i_psel && $rose(i_penable) && i_paddr[1:0] != 2'h0 |=> o_pslverr;
  endproperty
  property p_ro_write;
    i_psel && $rose(i_penable) && i_pwrite && i_paddr[9:2] == ramp_seq_pkg::IDX_STATUS
      |=> o_pslverr;
  endproperty
  property p_seg_one_active;
    o_segment_one |-> o_ramp_active && $past(o_ramp_active);
  endproperty
  property p_reset_clean;
    $fell(i_rst) |-> !o_ramp_active && o_ramp_offset == 32'h0000_0000;
  endproperty

  a_ready_timing: assert property (p_ready_timing) else $error("pready late or early");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
  a_ro_write: assert property (p_ro_write) else $error("status write not refused");
  a_seg_one_active: assert property (p_seg_one_active) else $error("bad segment one");
  a_reset_clean: assert property (p_reset_clean) else $error("ramp busy after reset");
endmodule

bind frequency_ramp_sequencer ramp_seq_checker #(.ADDR_W(ADDR_W)) chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_ramp_offset(o_ramp_offset), .o_ramp_active(o_ramp_active), .o_segment_one(o_segment_one)
);

`default_nettype wire

// [ramp_pin_driver.sv]
// model of the external controller that drives the two ramp pins
// assumes the bench calls drive between clock edges of i_clk
`timescale 1ns/1ps
`default_nettype none

module ramp_pin_driver (
  // clock
  input wire logic i_clk,
  // ramp pins
  output logic o_sweep_clock_pin = 1'b0,
  output logic o_sweep_direction_pin = 1'b0
);
  // ****************************************************************
  // pin levels, idle low, changed just after an edge and then held
  // ****************************************************************

  // set one pin: 0 is the clock pin, 1 the direction pin
  task automatic drive(input logic sel, input logic lvl);
    @(posedge i_clk);
    if (sel) o_sweep_direction_pin <= lvl;
    else o_sweep_clock_pin <= lvl;
  endtask
endmodule

`default_nettype wire

// [ramp_seq_pkg.sv]
// register map, field layout and state encoding of the frequency ramp sequencer
// assumes a 32-bit apb bus with word addressing of 16-bit registers
package ramp_seq_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_RUN_CONTROL = 8'h00;
  localparam logic [7:0] IDX_BURST_CONTROL = 8'h60;
  localparam logic [7:0] IDX_TRIGGER_SELECT = 8'h61;
  localparam logic [7:0] IDX_SEG_ZERO_STEP_HIGH = 8'h62;
  localparam logic [7:0] IDX_SEG_ZERO_STEP_LOW = 8'h63;
  localparam logic [7:0] IDX_SEG_ZERO_LENGTH = 8'h64;
  localparam logic [7:0] IDX_SEG_ZERO_SEQUENCE = 8'h65;
  localparam logic [7:0] IDX_SEG_ONE_STEP_HIGH = 8'h66;
  localparam logic [7:0] IDX_SEG_ONE_STEP_LOW = 8'h67;
  localparam logic [7:0] IDX_SEG_ONE_LENGTH = 8'h68;
  localparam logic [7:0] IDX_CAL_WAIT_AND_MODE = 8'h69;
  localparam logic [7:0] IDX_WAIT_SCALE = 8'h6A;
  localparam logic [7:0] IDX_STATUS = 8'h6B;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h6C;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h6D;
  localparam int NUM_CFG = 11;

  // ****************************************************************
  // writable masks and reset values of the configuration block
  // ****************************************************************
  localparam logic [NUM_CFG-1:0][15:0] CFG_MASK = {
    16'h0017, 16'hFFF3, 16'hFFFF, 16'hFFFF, 16'h3FFF,
    16'h0073, 16'hFFFF, 16'hFFFF, 16'hFFFD, 16'h87FB, 16'hFFFC};
  localparam logic [NUM_CFG-1:0][15:0] CFG_RESET = {
    16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int RUN_ENABLE_BIT = 15;
  localparam int BURST_ENABLE_BIT = 15;
  localparam int BURST_TOTAL_HI = 14;
  localparam int BURST_TOTAL_LO = 2;
  localparam int SEG_ZERO_RESTART_BIT = 15;
  localparam int TRIG_B_HI = 10;
  localparam int TRIG_B_LO = 7;
  localparam int TRIG_A_HI = 6;
  localparam int TRIG_A_LO = 3;
  localparam int SOURCE_HI = 1;
  localparam int SEG_ZERO_HALF_RATE_BIT = 0;
  localparam int STEP_HIGH_HI = 15;
  localparam int STEP_HIGH_LO = 2;
  localparam int SEG_ONE_STEP_HIGH_HI = 13;
  localparam int SEG_ONE_HALF_RATE_BIT = 6;
  localparam int SEG_ONE_RESTART_BIT = 5;
  localparam int SUCCESSOR_BIT = 4;
  localparam int CAL_WAIT_HI = 15;
  localparam int CAL_WAIT_LO = 6;
  localparam int MANUAL_BIT = 5;
  localparam int POST_CAL_BIT = 4;
  localparam int SCALE_HI = 2;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [3:0] TRIG_OFF = 4'h0;
  localparam logic [3:0] TRIG_CLOCK_RISE = 4'h1;
  localparam logic [3:0] TRIG_DIR_RISE = 4'h2;
  localparam logic [3:0] TRIG_ALWAYS = 4'h4;
  localparam logic [3:0] TRIG_CLOCK_FALL = 4'h9;
  localparam logic [3:0] TRIG_DIR_FALL = 4'hA;
  localparam logic [1:0] SRC_TRANSITION = 2'h0;
  localparam logic [1:0] SRC_TRIG_A = 2'h1;
  localparam logic [1:0] SRC_TRIG_B = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CAL,
    ST_SEG_ZERO,
    ST_SEG_ONE,
    ST_DONE
  } seq_state_t;

endpackage

// [tb_frequency_ramp_sequencer.sv]
// self-checking bench for the frequency ramp sequencer
// assumes the checker binds itself and the pin driver plays the controller
`timescale 1ns/1ps
`default_nettype none

module tb_frequency_ramp_sequencer;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic cal_done = 1'b1;
  logic o_pready, o_pslverr, o_ramp_active, o_segment_one, o_cal_request, ck_pin, dr_pin, er;
  logic [31:0] o_prdata, o_ramp_offset, rd;
  logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h9, 4'hA};
  int n_errors = 0;
  int checked = 0;
  int visits[$];
  int mx;

  // ****************************************************************
  // clock, design and pin driver
  // ****************************************************************
  always #2.5 i_clk = ~i_clk;

  frequency_ramp_sequencer #(.ADDR_W(12)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_sweep_clock_pin(ck_pin), .i_sweep_direction_pin(dr_pin),
    .i_cal_done(cal_done), .o_cal_request(o_cal_request), .o_ramp_offset(o_ramp_offset),
    .o_ramp_active(o_ramp_active), .o_segment_one(o_segment_one));

  ramp_pin_driver u_pins (.i_clk(i_clk), .o_sweep_clock_pin(ck_pin),
    .o_sweep_direction_pin(dr_pin));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that used up its bound ends the run
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      final_report();
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     input logic [1:0] lo);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, lo};
    pwdata <= {16'h0, wd};
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    guard(n, 16);
    rd = o_prdata;
    er = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] idx, input logic [15:0] v);
    apb(1'b1, idx, v, 2'h0);
  endtask

  // stop any run, then load the whole configuration block in order
  task automatic setup(input logic [15:0] v [11]);
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h0000);
    for (int i = 0; i < 11; i++) cfg(ramp_seq_pkg::IDX_BURST_CONTROL + 8'(i), v[i]);
  endtask

  // record segment visit lengths and per-cycle steps until the ramp stops
  task automatic watch(input logic half);
    logic pa, seg, act;
    logic [31:0] po;
    int k, n;
    pa = 1'b0;
    seg = 1'b0;
    po = 32'h0;
    k = 0;
    visits = {};
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      #1;
      act = (o_ramp_active === 1'b1);
      if (pa && (!act || seg !== o_segment_one)) begin
        visits.push_back(k);
        k = 0;
      end else if (act && pa && !(seg && half))
        check("ramp step", seg ? 32'hFFFF_FFFE : 32'h5, o_ramp_offset - po);
      if (pa && !act) break;
      if (act) k++;
      pa = act;
      seg = o_segment_one;
      po = o_ramp_offset;
    end
    guard(n, 200);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic regs_case();
    apb(1'b0, ramp_seq_pkg::IDX_WAIT_SCALE, 16'h0, 2'h0);
    check("wait_scale reset", 32'h7, rd);
    cfg(ramp_seq_pkg::IDX_TRIGGER_SELECT, 16'hFFFF);
    apb(1'b0, ramp_seq_pkg::IDX_TRIGGER_SELECT, 16'h0, 2'h0);
    check("trigger_select", 32'h87FB, rd);
    apb(1'b0, 8'h50, 16'h0, 2'h0);
    check("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, ramp_seq_pkg::IDX_SEG_ZERO_LENGTH, 16'h0, 2'h2);
    check("unaligned err", 32'h1, {31'h0, er});
    cfg(ramp_seq_pkg::IDX_STATUS, 16'hFFFF);
    check("read-only err", 32'h1, {31'h0, er});
  endtask

  // manual burst of three: zero, one, zero; steps +5 and -2
  task automatic burst_case(input logic half);
    int ex[3] = '{4, half ? 6 : 3, 4};
    setup('{16'h800C, 16'h0, 16'h0, 16'h5, 16'h4, half ? 16'h0050 : 16'h0010,
            16'h3FFF, 16'hFFFE, 16'h3, 16'h0020, 16'h0});
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h8000);
    watch(half);
    for (int i = 0; i < 3; i++)
      check("visit length", ex[i], visits[i]);
    apb(1'b0, ramp_seq_pkg::IDX_STATUS, 16'h0, 2'h0);
    check("burst done", 32'h4000, rd);
  endtask

  // manual burst of two counted on trigger a, which fires every cycle
  task automatic burst_trig_case();
    setup('{16'h8008, 16'h0021, 16'h0, 16'h5, 16'h10, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0020,
            16'h0010});
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h8000);
    watch(1'b0);
    check("post cal pulse", 32'h1, {31'h0, o_cal_request});
    check("burst by trigger", 32'h2, visits[0]);
  endtask

  // segment zero repeats with restart, so the offset never builds up
  task automatic restart_case();
    setup('{16'h0, 16'h8000, 16'h0, 16'h1, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h8000);
    mx = 0;
    repeat (60) begin
      @(posedge i_clk);
      if (o_ramp_active === 1'b1 && $signed(o_ramp_offset) > mx) mx = $signed(o_ramp_offset);
    end
    check("restart peak", 32'h3, mx);
  endtask

  // wait count 3 scaled by 2, against a calibration released after hold cycles
  task automatic cal_case(input int hold, input int lo, input int hi);
    int n;
    setup('{16'h0, 16'h0, 16'h0, 16'h1, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0, 16'h00C0, 16'h1});
    cal_done <= (hold == 0);
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h8000);
    n = 0;
    while (o_cal_request !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    guard(n, 40);
    n = 0;
    while (o_ramp_active !== 1'b1 && n < 80) begin
      @(posedge i_clk);
      n++;
      if (n == hold) cal_done <= 1'b1;
    end
    guard(n, 80);
    check("cal wait", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask

  // segment zero left by trigger a or b; other pin first, then rise, then fall
  task automatic trig_case(input logic b, input logic [3:0] code);
    logic pin;
    logic [15:0] ts;
    pin = (code[1:0] == 2'h2);
    ts = b ? {5'h0, code, 7'h0} : {9'h0, code, 3'h0};
    setup('{16'h0, ts, 16'h0, 16'h0, 16'h0, b ? 16'h0012 : 16'h0011,
            16'h0, 16'h0, 16'h0, 16'h0023, 16'h0});
    cfg(ramp_seq_pkg::IDX_RUN_CONTROL, 16'h8000);
    u_pins.drive(!pin, 1'b1);
    repeat (6) @(posedge i_clk);
    u_pins.drive(!pin, 1'b0);
    repeat (6) @(posedge i_clk);
    check("other pin", {31'h0, code == 4'h4}, {31'h0, o_segment_one});
    u_pins.drive(pin, 1'b1);
    repeat (6) @(posedge i_clk);
    check("rise", {31'h0, code inside {4'h1, 4'h2, 4'h4}}, {31'h0, o_segment_one});
    u_pins.drive(pin, 1'b0);
    repeat (6) @(posedge i_clk);
    check("fall", {31'h0, code != 4'h0}, {31'h0, o_segment_one});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    regs_case();
    burst_case(1'b0);
    burst_case(1'b1);
    burst_trig_case();
    restart_case();
    cal_case(0, 5, 9);
    cal_case(20, 20, 24);
    for (int i = 0; i < 12; i++) trig_case(i >= 6, codes[i % 6]);
    final_report();
  end
endmodule

`default_nettype wire
